//--- video_cfg_defines.svh
// Function
// [RQ1] Lane field code selects four down to one
// [RQ2] Leader check tolerates one bit unless strict
// [RQ3] Data equalizer: none, 1 dB, 2 dB
// [RQ4] Clock equalizer: none, 1 dB, 2 dB
// [RQ5] Software programs band code in 5 MHz steps
// [RQ6] Active video polarity set by bit 7
// [RQ7] Line sync polarity set by bit 6
// [RQ8] Frame sync polarity set by bit 5
// [RQ9] Bit 3 picks 18 or 24 bpp output
// [RQ10] Bit 1 picks fourth lane MSB or LSB
// [RQ11] Software keeps bit 1 clear for 18 bpp
// [RQ12] Bit 1 without 24 bpp truncates to 18
// [RQ13] Software leaves reserved format bits at default
`ifndef VIDEO_CFG_DEFINES_SVH
`define VIDEO_CFG_DEFINES_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define IDX_LANE_SETUP   6'h10
`define IDX_EQ_SETUP     6'h11
`define IDX_BAND_SETUP   6'h12
`define IDX_OUT_FORMAT   6'h18
`define IDX_STATUS       6'h1F

// ==========================================================
// Reset values and writable bit masks
`define RST_LANE_SETUP   8'h18
`define RST_EQ_SETUP     8'h00
`define RST_BAND_SETUP   8'h00
`define RST_OUT_FORMAT   8'h60
`define WMASK_LANE       8'h19
`define WMASK_EQ         8'hCC
`define WMASK_BAND       8'hFF
`define WMASK_FORMAT     8'hEA

// ==========================================================
// Field positions
`define LANE_CNT_HI      4
`define LANE_CNT_LO      3
`define STRICT_BIT       0
`define DATA_EQ_HI       7
`define DATA_EQ_LO       6
`define CLK_EQ_HI        3
`define CLK_EQ_LO        2
`define ACT_LOW_BIT      7
`define LINE_LOW_BIT     6
`define FRAME_LOW_BIT    5
`define WIDE_BIT         3
`define LOW_BITS_BIT     1

// ==========================================================
// Band code limits and bus responses
`define BAND_MIN         8'h08
`define BAND_MAX         8'h64
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

//--- video_cfg_pkg.sv
`default_nettype none
package video_cfg_pkg;

   // Incoming pixel with syncs, 8 bits per colour
   typedef struct packed {
      logic       active;
      logic       line_sync;
      logic       frame_sync;
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } video_in_t;

   // Output levels and lane payload
   typedef struct packed {
      logic       active_level;
      logic       line_level;
      logic       frame_level;
      logic [5:0] red;
      logic [5:0] green;
      logic [5:0] blue;
      logic [5:0] fourth;
      logic       fourth_en;
   } pixel_out_t;

   // Receiver settings driven to the front end
   typedef struct packed {
      logic [3:0] lane_enable;
      logic       strict;
      logic [1:0] data_eq_db;
      logic [1:0] clk_eq_db;
      logic [7:0] band;
   } rx_ctrl_t;

endpackage

`default_nettype wire

//--- leader_check.sv
`timescale 1ns/1ns
`default_nettype none

module leader_check
   import video_cfg_pkg::*;
#(
   parameter logic [7:0] LEADER_PATTERN = 8'hB8
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Candidate byte
   input  wire logic       byte_valid,
   input  wire logic [7:0] byte_data,
   input  wire logic       strict,
   // Verdict, one cycle after the byte
   output var  logic       accept,
   output var  logic       reject
);

   // Count of bits that differ from the leader
   function automatic logic [3:0] bit_errors(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'b000, v[i]};
      end
      return n;
   endfunction

   wire [3:0] errs = bit_errors(byte_data ^ LEADER_PATTERN);
   // [RQ2] tolerance of one
   wire       ok   = (errs == 4'h0) | (~strict & (errs == 4'h1));

   // Verdict register
   always_ff @(posedge clk) begin
      if (srst) begin
         accept <= 1'b0;
         reject <= 1'b0;
      end else begin
         accept <= byte_valid & ok;
         reject <= byte_valid & ~ok;
      end
   end

endmodule

`default_nettype wire

//--- video_cfg_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "video_cfg_defines.svh"

module video_cfg_regs
   import video_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       SRST,
   // AXI4-Lite write address and data
   input  wire logic [7:0] AWADDR,
   input  wire logic       AWVALID,
   output var  logic       AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0] WSTRB,
   input  wire logic       WVALID,
   output var  logic       WREADY,
   // AXI4-Lite write response
   output var  logic [1:0] BRESP,
   output var  logic       BVALID,
   input  wire logic       BREADY,
   // AXI4-Lite read
   input  wire logic [7:0] ARADDR,
   input  wire logic       ARVALID,
   output var  logic       ARREADY,
   output var  logic [31:0] RDATA,
   output var  logic [1:0] RRESP,
   output var  logic       RVALID,
   input  wire logic       RREADY,
   // Receiver side
   input  wire logic       LEADER_VALID,
   input  wire logic [7:0] LEADER_BYTE,
   output var  logic       LEADER_ACCEPT,
   output var  logic       LEADER_REJECT,
   output var  rx_ctrl_t   RX_CTRL,
   // Video path
   input  wire logic       SOURCE_18BPP,
   input  wire video_in_t  VIDEO_IN,
   output var  pixel_out_t VIDEO_OUT
);

   // ==========================================================
   // Decoding functions

   // Index is one of the mapped registers
   function automatic logic is_mapped(input logic [5:0] idx);
      return (idx == `IDX_LANE_SETUP) | (idx == `IDX_EQ_SETUP) |
             (idx == `IDX_BAND_SETUP) | (idx == `IDX_OUT_FORMAT) |
             (idx == `IDX_STATUS);
   endfunction

   // Equalizer code to gain; reserved code falls back to none
   function automatic logic [1:0] eq_db(input logic [1:0] code);
      case (code)
         2'b01:   return 2'd1;
         2'b11:   return 2'd2;
         default: return 2'd0;
      endcase
   endfunction

   // Lane code to enable mask
   function automatic logic [3:0] lane_mask(input logic [1:0] code);
      case (code)
         2'b00:   return 4'b1111;
         2'b01:   return 4'b0111;
         2'b10:   return 4'b0011;
         default: return 4'b0001;
      endcase
   endfunction

   // ==========================================================
   // Bus state
   logic        awready_reg;
   logic        wready_reg;
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [7:0]  aw_addr_reg;
   logic [7:0]  w_data_reg;
   logic        w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   // Configuration and status state
   logic [7:0]  lane_reg;
   logic [7:0]  eq_reg;
   logic [7:0]  band_reg;
   logic [7:0]  fmt_reg;
   logic [3:0]  lead_cnt_reg;
   rx_ctrl_t    rx_reg;
   pixel_out_t  pix_reg;
   logic        accept_w;
   logic        reject_w;

   // ==========================================================
   // Write channel decode
   wire       aw_fire = AWVALID & awready_reg;
   wire       w_fire  = WVALID & wready_reg;
   wire       wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
   wire [5:0] wr_idx  = aw_addr_reg[7:2];
   wire       wr_en   = wr_fire & w_strb_reg;
   wire       wr_lane = wr_en & (wr_idx == `IDX_LANE_SETUP);
   wire       wr_eq   = wr_en & (wr_idx == `IDX_EQ_SETUP);
   wire       wr_band = wr_en & (wr_idx == `IDX_BAND_SETUP);
   wire       wr_fmt  = wr_en & (wr_idx == `IDX_OUT_FORMAT);
   wire [1:0] wr_resp = is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;

   // Next register values; reserved bits never take a write
   // [RQ13] reserved bits kept
   wire [7:0] lane_next = wr_lane ? (w_data_reg & `WMASK_LANE) : lane_reg;
   wire [7:0] eq_next   = wr_eq   ? (w_data_reg & `WMASK_EQ)   : eq_reg;
   wire [7:0] band_next = wr_band ? (w_data_reg & `WMASK_BAND) : band_reg;
   wire [7:0] fmt_next  = wr_fmt  ? (w_data_reg & `WMASK_FORMAT)
                                  : fmt_reg;

   // ==========================================================
   // Field extraction
   wire [1:0] rx_lane_count           = lane_reg[`LANE_CNT_HI:`LANE_CNT_LO];
   wire       strict_leader_check     = lane_reg[`STRICT_BIT];
   wire [1:0] data_lane_equalizer     = eq_reg[`DATA_EQ_HI:`DATA_EQ_LO];
   wire [1:0] clock_lane_equalizer    = eq_reg[`CLK_EQ_HI:`CLK_EQ_LO];
   wire       active_video_low        = fmt_reg[`ACT_LOW_BIT];
   wire       line_sync_low           = fmt_reg[`LINE_LOW_BIT];
   wire       frame_sync_low          = fmt_reg[`FRAME_LOW_BIT];
   wire       wide_color_enable       = fmt_reg[`WIDE_BIT];
   wire       low_bits_on_fourth_lane = fmt_reg[`LOW_BITS_BIT];

   // Status bits; band range is only reported, the front end
   // gets the code unchanged
   // [RQ5] band code range
   wire       band_ok   = (band_reg >= `BAND_MIN) &
                          (band_reg <= `BAND_MAX);
   wire       deq_rsv   = (data_lane_equalizer == 2'b10);
   wire       ceq_rsv   = (clock_lane_equalizer == 2'b10);
   // [RQ11] format conflict flagged
   wire       fmt_clash = low_bits_on_fourth_lane & SOURCE_18BPP;
   wire [7:0] status    = {lead_cnt_reg, fmt_clash, ceq_rsv, deq_rsv,
                           band_ok};

   // ==========================================================
   // Read mux
   wire       ar_fire = ARVALID & arready_reg;
   wire [5:0] rd_idx  = ARADDR[7:2];
   wire [7:0] rd_byte =
      (rd_idx == `IDX_LANE_SETUP) ? lane_reg :
      (rd_idx == `IDX_EQ_SETUP)   ? eq_reg   :
      (rd_idx == `IDX_BAND_SETUP) ? band_reg :
      (rd_idx == `IDX_OUT_FORMAT) ? fmt_reg  :
      (rd_idx == `IDX_STATUS)     ? status   : 8'h00;
   wire [1:0] rd_resp = is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;

   // ==========================================================
   // Video mapping
   // [RQ9] fourth lane on in 24 bpp
   wire       lane4_on  = wide_color_enable;
   // [RQ10] MSB or LSB on fourth lane
   wire       msb_out   = wide_color_enable & ~low_bits_on_fourth_lane;
   // [RQ12] truncation drops two LSBs
   wire [5:0] red_main  = msb_out ? VIDEO_IN.red[5:0]
                                  : VIDEO_IN.red[7:2];
   wire [5:0] grn_main  = msb_out ? VIDEO_IN.green[5:0]
                                  : VIDEO_IN.green[7:2];
   wire [5:0] blu_main  = msb_out ? VIDEO_IN.blue[5:0]
                                  : VIDEO_IN.blue[7:2];
   wire [5:0] fourth_hi = {VIDEO_IN.red[7:6], VIDEO_IN.green[7:6],
                           VIDEO_IN.blue[7:6]};
   wire [5:0] fourth_lo = {VIDEO_IN.red[1:0], VIDEO_IN.green[1:0],
                           VIDEO_IN.blue[1:0]};
   wire [5:0] fourth    = ~lane4_on ? 6'h00 :
                          low_bits_on_fourth_lane ? fourth_lo : fourth_hi;

   // ==========================================================
   // Write address and data capture, taken in either order
   always_ff @(posedge CLK) begin
      if (SRST) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 8'h00;
         w_strb_reg  <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= AWADDR;
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
         if (w_fire) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= WDATA[7:0];
            w_strb_reg <= WSTRB[0];
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
         // Ready again only once the response has gone
         awready_reg <= ~aw_hold_reg & ~aw_fire & ~bvalid_reg & ~wr_fire;
         wready_reg  <= ~w_hold_reg & ~w_fire & ~bvalid_reg & ~wr_fire;
      end
   end

   // Write response
   always_ff @(posedge CLK) begin
      if (SRST) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_resp;
      end else if (BREADY) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read channel, one read at a time
   always_ff @(posedge CLK) begin
      if (SRST) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= `RESP_OKAY;
      end else if (ar_fire) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= {24'h00_0000, rd_byte};
         rresp_reg   <= rd_resp;
      end else if (rvalid_reg & RREADY) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end else if (~rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Configuration registers
   always_ff @(posedge CLK) begin
      if (SRST) begin
         lane_reg <= `RST_LANE_SETUP;
         eq_reg   <= `RST_EQ_SETUP;
         band_reg <= `RST_BAND_SETUP;
         fmt_reg  <= `RST_OUT_FORMAT;
      end else begin
         lane_reg <= lane_next;
         eq_reg   <= eq_next;
         band_reg <= band_next;
         fmt_reg  <= fmt_next;
      end
   end

   // Accepted leader count, wraps; only reset clears it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         lead_cnt_reg <= 4'h0;
      end else if (accept_w) begin
         lead_cnt_reg <= lead_cnt_reg + 4'h1;
      end
   end

   // ==========================================================
   // Receiver settings, one cycle behind the registers
   always_ff @(posedge CLK) begin
      if (SRST) begin
         rx_reg <= '0;
      end else begin
         // [RQ1] lane count decode
         rx_reg.lane_enable <= lane_mask(rx_lane_count);
         rx_reg.strict      <= strict_leader_check;
         // [RQ3] data equalizer gain
         rx_reg.data_eq_db  <= eq_db(data_lane_equalizer);
         // [RQ4] clock equalizer gain
         rx_reg.clk_eq_db   <= eq_db(clock_lane_equalizer);
         rx_reg.band        <= band_reg;
      end
   end

   // Leader checker against the strictness setting
   leader_check u_leader (
      .clk        (CLK),
      .srst       (SRST),
      .byte_valid (LEADER_VALID),
      .byte_data  (LEADER_BYTE),
      .strict     (strict_leader_check),
      .accept     (accept_w),
      .reject     (reject_w)
   );

   // ==========================================================
   // Output pixel register; idle syncs rest at inactive level once out of reset, while reset drives every level low
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pix_reg <= '0;
      end else begin
         // [RQ6] active video polarity
         pix_reg.active_level <= VIDEO_IN.active ^ active_video_low;
         // [RQ7] line sync polarity
         pix_reg.line_level   <= VIDEO_IN.line_sync ^ line_sync_low;
         // [RQ8] frame sync polarity
         pix_reg.frame_level  <= VIDEO_IN.frame_sync ^ frame_sync_low;
         pix_reg.red          <= red_main;
         pix_reg.green        <= grn_main;
         pix_reg.blue         <= blu_main;
         pix_reg.fourth       <= fourth;
         pix_reg.fourth_en    <= lane4_on;
      end
   end

   // ==========================================================
   // Output drive
   assign AWREADY       = awready_reg;
   assign WREADY        = wready_reg;
   assign BVALID        = bvalid_reg;
   assign BRESP         = bresp_reg;
   assign ARREADY       = arready_reg;
   assign RVALID        = rvalid_reg;
   assign RDATA         = rdata_reg;
   assign RRESP         = rresp_reg;
   assign RX_CTRL       = rx_reg;
   assign VIDEO_OUT     = pix_reg;
   assign LEADER_ACCEPT = accept_w;
   assign LEADER_REJECT = reject_w;

endmodule

`default_nettype wire

//--- video_cfg_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checks for the configuration bank
module video_cfg_regs_checker
   import video_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       SRST,
   // Bus handshakes
   input  wire logic       AWVALID,
   input  wire logic       AWREADY,
   input  wire logic       WVALID,
   input  wire logic       WREADY,
   input  wire logic       BVALID,
   input  wire logic       ARVALID,
   input  wire logic       ARREADY,
   input  wire logic       RVALID,
   // Receiver side
   input  wire logic       LEADER_VALID,
   input  wire logic [7:0] LEADER_BYTE,
   input  wire logic       LEADER_ACCEPT,
   input  wire logic       LEADER_REJECT,
   input  wire rx_ctrl_t   RX_CTRL,
   // Video path
   input  wire video_in_t  VIDEO_IN,
   input  wire pixel_out_t VIDEO_OUT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   write_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY
      |-> ##2 BVALID) else $error("write answer late");
   read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   lane_code_a: assert property (
      !$past(SRST) |-> RX_CTRL.lane_enable inside {4'h1, 4'h3, 4'h7, 4'hF})
      else $error("lane enable pattern illegal");
   verdict_pulse_a: assert property (
      LEADER_VALID |=> LEADER_ACCEPT != LEADER_REJECT)
      else $error("leader verdict missing or doubled");
   verdict_cause_a: assert property (
      !LEADER_VALID |=> !LEADER_ACCEPT && !LEADER_REJECT)
      else $error("leader verdict without byte");
   strict_reject_a: assert property (
      LEADER_VALID && LEADER_BYTE != 8'hB8 ##1 RX_CTRL.strict
      |-> LEADER_REJECT) else $error("strict check let an error pass");
   fourth_off_a: assert property (
      !VIDEO_OUT.fourth_en |-> VIDEO_OUT.fourth == 6'h00)
      else $error("disabled fourth lane carries data");
   narrow_output_a: assert property (
      !$past(SRST) && !VIDEO_OUT.fourth_en
      |-> VIDEO_OUT.blue == $past(VIDEO_IN.blue[7:2]))
      else $error("narrow output not upper bits");
   fourth_map_a: assert property (
      VIDEO_OUT.fourth_en
      |-> (VIDEO_OUT.green == $past(VIDEO_IN.green[5:0])
      && VIDEO_OUT.fourth[3:2] == $past(VIDEO_IN.green[7:6]))
      || (VIDEO_OUT.green == $past(VIDEO_IN.green[7:2])
      && VIDEO_OUT.fourth[3:2] == $past(VIDEO_IN.green[1:0])))
      else $error("fourth lane split wrong");
endmodule

bind video_cfg_regs video_cfg_regs_checker i_video_cfg_regs_checker (.*);
`default_nettype wire

//--- test_dsi_lvds_video_config_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_dsi_lvds_video_config_regs
   import video_cfg_pkg::*;
;
   // ==========================================
   // Stimulus and observed ports
   logic        CLK = 0, SRST = 1;
   logic [7:0]  AWADDR = 0, ARADDR = 0, LEADER_BYTE = 0;
   logic [31:0] WDATA = 0, RDATA;
   logic [3:0]  WSTRB = 0;
   logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0;
   logic        RREADY = 0, LEADER_VALID = 0, SOURCE_18BPP = 0;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic        LEADER_ACCEPT, LEADER_REJECT;
   logic [1:0]  BRESP, RRESP;
   video_in_t   VIDEO_IN = '0;
   rx_ctrl_t    RX_CTRL;
   pixel_out_t  VIDEO_OUT;
   int          mismatches = 0, checked = 0, cycles = 0;

   video_cfg_regs i_video_cfg_regs (.*);

   // ==========================================
   // Clock and hang guard
   initial begin
      forever #5 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end

   // ==========================================
   // Shared helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                     input logic [1:0] er);
      bit aw, w;
      @(posedge CLK);
      AWADDR  <= {idx, 2'b00};
      WDATA   <= {24'h0, d};
      WSTRB   <= 4'hF;
      AWVALID <= 1'b1;
      WVALID  <= 1'b1;
      BREADY  <= 1'b1;
      aw = 1;
      w = 1;
      do begin
         @(posedge CLK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         aw = aw && !AWREADY;
         w = w && !WREADY;
      end while (aw || w);
      do @(posedge CLK); while (!BVALID);
      BREADY <= 1'b0;
      chk({30'h0, BRESP}, {30'h0, er});
   endtask

   task automatic rd(input logic [5:0] idx, input logic [1:0] er,
                     output logic [31:0] d);
      @(posedge CLK);
      ARADDR  <= {idx, 2'b00};
      ARVALID <= 1'b1;
      RREADY  <= 1'b1;
      do @(posedge CLK); while (!ARREADY);
      ARVALID <= 1'b0;
      do @(posedge CLK); while (!RVALID);
      RREADY <= 1'b0;
      d = RDATA;
      chk({30'h0, RRESP}, {30'h0, er});
   endtask

   task automatic rc(input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      rd(idx, 2'b00, d);
      chk(d, exp);
   endtask

   // Verdict lands one edge after the byte is taken
   task automatic leader(input logic [7:0] b, input logic [1:0] exp);
      @(posedge CLK);
      LEADER_VALID <= 1'b1;
      LEADER_BYTE  <= b;
      @(posedge CLK);
      LEADER_VALID <= 1'b0;
      @(posedge CLK);
      chk({30'h0, LEADER_ACCEPT, LEADER_REJECT}, {30'h0, exp});
   endtask

   function automatic logic [1:0] eqv(input int c);
      return {c == 3, c == 1};
   endfunction

   // Output word worked out from the format byte
   function automatic pixel_out_t expv(input logic [7:0] f,
                                       input video_in_t v);
      pixel_out_t e;
      e.active_level = v.active ^ f[7];
      e.line_level = v.line_sync ^ f[6];
      e.frame_level = v.frame_sync ^ f[5];
      e.fourth_en = f[3];
      if (f[3] && !f[1]) begin
         e.red = v.red[5:0];
         e.green = v.green[5:0];
         e.blue = v.blue[5:0];
         e.fourth = {v.red[7:6], v.green[7:6], v.blue[7:6]};
      end else begin
         e.red = v.red[7:2];
         e.green = v.green[7:2];
         e.blue = v.blue[7:2];
         e.fourth = f[3] ? {v.red[1:0], v.green[1:0], v.blue[1:0]} : 6'h0;
      end
      return e;
   endfunction

   // ==========================================
   // Scenarios
   task automatic t_reset();
      rc(6'h10, 32'h18);
      rc(6'h11, 32'h00);
      rc(6'h12, 32'h00);
      rc(6'h18, 32'h60);
      chk({15'h0, RX_CTRL}, {15'h0, 4'h1, 13'h0});
   endtask

   // Reserved bits written as ones must read back clear
   task automatic t_lanes();
      for (int c = 0; c < 4; c++) begin
         wr(6'h10, {3'h7, 2'(c), 3'h7}, 2'b00);
         repeat (2) @(posedge CLK);
         chk({28'h0, RX_CTRL.lane_enable}, 32'hF >> c);
         chk({31'h0, RX_CTRL.strict}, 32'h1);
         rc(6'h10, {27'h0, 2'(c), 3'h1});
      end
   endtask

   // Strict first (left set by the lane loop), then tolerant
   task automatic t_leader();
      leader(8'hB8, 2'b10);
      leader(8'hB9, 2'b01);
      wr(6'h10, 8'h18, 2'b00);
      leader(8'hF8, 2'b10);
      leader(8'h39 ^ 8'h01, 2'b10);
      leader(8'h39, 2'b01);
   endtask

   task automatic t_eq();
      for (int c = 0; c < 4; c++) begin
         wr(6'h11, {2'(c), 2'h3, 2'(3 - c), 2'h3}, 2'b00);
         repeat (2) @(posedge CLK);
         chk({28'h0, RX_CTRL.data_eq_db, RX_CTRL.clk_eq_db},
             {28'h0, eqv(c), eqv(3 - c)});
         rc(6'h11, {24'h0, 2'(c), 2'h0, 2'(3 - c), 2'h0});
      end
   endtask

   // Reset code is reserved, so the range flag starts clear
   task automatic t_band();
      logic [31:0] d;
      rd(6'h1F, 2'b00, d);
      chk(d & 32'h1, 32'h0);
      wr(6'h12, 8'h08, 2'b00);
      rc(6'h12, 32'h08);
      wr(6'h12, 8'h64, 2'b00);
      rc(6'h12, 32'h64);
      chk({24'h0, RX_CTRL.band}, 32'h64);
      rd(6'h1F, 2'b00, d);
      chk(d & 32'h1, 32'h1);
   endtask

   task automatic t_video();
      logic [7:0] fmt [6] = '{8'h60, 8'h00, 8'hE0, 8'h08, 8'h0A, 8'h02};
      logic [31:0] d;
      for (int i = 0; i < 6; i++) begin
         VIDEO_IN <= {i[0], 1'b1, ~i[0], 8'hC5, 8'h3A, 8'h96};
         wr(6'h18, fmt[i], 2'b00);
         repeat (3) @(posedge CLK);
         chk({4'h0, VIDEO_OUT}, {4'h0, expv(fmt[i], VIDEO_IN)});
      end
      // Every writable format bit set reads back; reserved bits are written as zero
      wr(6'h18, 8'hEA, 2'b00);
      rc(6'h18, 32'hEA);
      // Narrow source only once the fourth-lane LSB bit (bit 1) is clear
      wr(6'h18, 8'h00, 2'b00);
      SOURCE_18BPP <= 1'b1;
      repeat (2) @(posedge CLK);
      rd(6'h1F, 2'b00, d);
      chk(d & 32'h8, 32'h0);
   endtask

   // Unmapped place refuses and reads zero
   task automatic t_unmapped();
      logic [31:0] d;
      wr(6'h20, 8'h5A, 2'b10);
      rd(6'h20, 2'b10, d);
      chk(d, 32'h0);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (20) @(posedge CLK);
      SRST <= 1'b0;
      t_reset();
      t_lanes();
      t_leader();
      t_eq();
      t_band();
      t_video();
      t_unmapped();
      conclude();
   end
endmodule
`default_nettype wire
